// ===== hdl/charger_regs_pkg.sv
// shared constants and types for the input-limit and conversion register slice
package charger_regs_pkg;

   // ****************************************************************
   // register offsets
   // ****************************************************************
   localparam logic [7:0] INPUT_LIMIT_CFG_OFFSET   = 8'h0d;
   localparam logic [7:0] THERMAL_BATTERY_OFFSET   = 8'h0e;
   localparam logic [7:0] SYSTEM_VOLTAGE_OFFSET    = 8'h0f;
   localparam logic [7:0] RESERVED_SLOT_OFFSET     = 8'h10;

   // ****************************************************************
   // field positions and reset values
   // ****************************************************************
   localparam int         METHOD_SELECT_BIT        = 7;
   localparam int         THERMAL_FLAG_BIT         = 7;
   localparam logic       METHOD_SELECT_DEFAULT    = 1'b0;
   localparam logic [6:0] ABS_LIMIT_DEFAULT        = 7'h12;
   localparam logic [7:0] RESERVED_READ_VALUE      = 8'h00;
   localparam logic [7:0] UNMAPPED_READ_VALUE      = 8'h00;

   // ****************************************************************
   // absolute limit scaling, millivolts
   // ****************************************************************
   localparam logic [13:0] ABS_LIMIT_OFFSET_MV     = 14'd2600;
   localparam logic [13:0] ABS_LIMIT_STEP_MV       = 14'd100;

   // ****************************************************************
   // serial target address (value is arbitrary)
   // ****************************************************************
   localparam logic [6:0] TARGET_ADDRESS_DEFAULT   = 7'h2a;

   // ****************************************************************
   // carriers
   // ****************************************************************
   typedef struct packed {
      logic       thermal_regulation;
      logic [6:0] battery_code;
      logic [6:0] system_code;
   } charger_status_type;

   typedef struct packed {
      logic       strobe;
      logic [7:0] addr;
      logic [7:0] data;
   } reg_write_type;

endpackage

// ===== hdl/input_limit_regs.sv
// input voltage limit configuration and conversion readback registers
`timescale 1ns/10ps
`default_nettype none
module input_limit_regs
   import charger_regs_pkg::*;
#(
   parameter logic [6:0] TARGET_ADDRESS = charger_regs_pkg::TARGET_ADDRESS_DEFAULT
) (
   // clock and reset
   input  wire logic                                sys_clk_i,
   input  wire logic                                rst_i,
   // serial pins
   input  wire logic                                scl_i,
   input  wire logic                                sda_i,
   output logic                                     sda_o,
   output logic                                     sda_oe_o,
   // charger core
   input  wire logic                                input_attached_i,
   input  wire charger_regs_pkg::charger_status_type status_i,
   output logic                                     use_absolute_limit_o,
   output logic [13:0]                              absolute_limit_mv_o
);
   import charger_regs_pkg::*;

   // ****************************************************************
   // serial engine
   // ****************************************************************
   logic [7:0]    pointer;
   logic [7:0]    read_data;
   reg_write_type host_write;

   serial_target #(
      .TARGET_ADDRESS (TARGET_ADDRESS)
   ) u_target (
      .sys_clk_i   (sys_clk_i),
      .rst_i       (rst_i),
      .scl_i       (scl_i),
      .sda_i       (sda_i),
      .sda_oe_o    (sda_oe_o),
      .read_data_i (read_data),
      .pointer_o   (pointer),
      .write_o     (host_write)
   );

   // open-drain: only ever pulls low
   always_ff @(posedge sys_clk_i) begin
      sda_o <= 1'b0;
   end

   // ****************************************************************
   // configuration register
   // ****************************************************************
   logic       attached_reg;
   logic       method_reg, method_next;
   logic [6:0] abs_code_reg, abs_code_next;
   logic       attach_edge;
   logic       use_abs_next;
   logic [13:0] limit_mv_next;

   assign attach_edge = input_attached_i & ~attached_reg;

   always_comb begin
      method_next   = method_reg;
      abs_code_next = abs_code_reg;
      // attach reload beats a same-cycle host write
      if (attach_edge) begin
         method_next   = METHOD_SELECT_DEFAULT;
         abs_code_next = ABS_LIMIT_DEFAULT;
      end else if (host_write.strobe && host_write.addr == INPUT_LIMIT_CFG_OFFSET) begin
         method_next   = host_write.data[METHOD_SELECT_BIT];
         abs_code_next = host_write.data[6:0];
      end
      use_abs_next  = method_reg;
      limit_mv_next = ABS_LIMIT_OFFSET_MV
                    + 14'({7'h00, abs_code_reg} * ABS_LIMIT_STEP_MV);
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         attached_reg         <= 1'b0;
         method_reg           <= METHOD_SELECT_DEFAULT;
         abs_code_reg         <= ABS_LIMIT_DEFAULT;
         use_absolute_limit_o <= METHOD_SELECT_DEFAULT;
         absolute_limit_mv_o  <= ABS_LIMIT_OFFSET_MV;
      end else begin
         attached_reg         <= input_attached_i;
         method_reg           <= method_next;
         abs_code_reg         <= abs_code_next;
         use_absolute_limit_o <= use_abs_next;
         absolute_limit_mv_o  <= limit_mv_next;
      end
   end

   // ****************************************************************
   // read mux
   // ****************************************************************
   // status reads are live, so a byte reflects the core at shift-out time
   always_comb begin
      unique case (pointer)
         INPUT_LIMIT_CFG_OFFSET: read_data = {method_reg, abs_code_reg};
         THERMAL_BATTERY_OFFSET: read_data = {status_i.thermal_regulation,
                                              status_i.battery_code};
         SYSTEM_VOLTAGE_OFFSET:  read_data = {1'b0, status_i.system_code};
         RESERVED_SLOT_OFFSET:   read_data = RESERVED_READ_VALUE;
         default:                read_data = UNMAPPED_READ_VALUE;
      endcase
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   sequence attach_edge_s;
      !input_attached_i ##1 input_attached_i;
   endsequence

   relative_mode_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      !method_reg |=> !use_absolute_limit_o)
      else $error("relative mode not applied");

   absolute_value_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      $stable(abs_code_reg) && method_reg |=> use_absolute_limit_o &&
      absolute_limit_mv_o == 14'd2600 + 14'({7'h00, $past(abs_code_reg)} * 14'd100))
      else $error("absolute limit value wrong");

   method_reload_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      attach_edge_s |=> !method_reg ##1 !use_absolute_limit_o)
      else $error("method bit not reloaded on attach");

   code_reload_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      attach_edge_s |=> abs_code_reg == ABS_LIMIT_DEFAULT)
      else $error("limit code not reloaded on attach");

   power_on_default_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      $fell(rst_i) |-> abs_code_reg == ABS_LIMIT_DEFAULT && !method_reg)
      else $error("power-on default wrong");

   thermal_read_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      pointer == THERMAL_BATTERY_OFFSET |-> read_data[7] == status_i.thermal_regulation &&
      read_data[6:0] == status_i.battery_code)
      else $error("thermal flag readback wrong");

   system_read_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      pointer == SYSTEM_VOLTAGE_OFFSET |-> read_data == {1'b0, status_i.system_code})
      else $error("system code readback wrong");

   readonly_write_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      host_write.strobe && host_write.addr != INPUT_LIMIT_CFG_OFFSET && !attach_edge
      |=> $stable(method_reg) && $stable(abs_code_reg))
      else $error("read-only write changed config");

endmodule
`default_nettype wire

// ===== hdl/serial_target.sv
// two-wire serial target: byte framing, pointer and write strobe
`timescale 1ns/10ps
`default_nettype none
module serial_target
   import charger_regs_pkg::*;
#(
   parameter logic [6:0] TARGET_ADDRESS = charger_regs_pkg::TARGET_ADDRESS_DEFAULT
) (
   // clock and reset
   input  wire logic                            sys_clk_i,
   input  wire logic                            rst_i,
   // serial pins
   input  wire logic                            scl_i,
   input  wire logic                            sda_i,
   output logic                                 sda_oe_o,
   // register side
   input  wire logic [7:0]                      read_data_i,
   output logic [7:0]                           pointer_o,
   output charger_regs_pkg::reg_write_type      write_o
);
   import charger_regs_pkg::*;

   typedef enum logic [5:0] {
      ST_IDLE  = 6'b000001,
      ST_ADDR  = 6'b000010,
      ST_PTR   = 6'b000100,
      ST_WDATA = 6'b001000,
      ST_RDATA = 6'b010000,
      ST_ACK   = 6'b100000
   } target_state_type;

   // ****************************************************************
   // pin synchronisers
   // ****************************************************************
   logic [2:0] scl_sync_reg;
   logic [2:0] sda_sync_reg;
   // reset to the idle-high bus level so no false edge follows reset
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         scl_sync_reg <= 3'b111;
         sda_sync_reg <= 3'b111;
      end else begin
         scl_sync_reg <= {scl_sync_reg[1:0], scl_i};
         sda_sync_reg <= {sda_sync_reg[1:0], sda_i};
      end
   end

   logic scl_rise, scl_fall, start_seen, stop_seen, sda_now;
   assign sda_now    = sda_sync_reg[1];
   assign scl_rise   = scl_sync_reg[1] & ~scl_sync_reg[2];
   assign scl_fall   = ~scl_sync_reg[1] & scl_sync_reg[2];
   assign start_seen = scl_sync_reg[1] & sda_sync_reg[2] & ~sda_sync_reg[1];
   assign stop_seen  = scl_sync_reg[1] & ~sda_sync_reg[2] & sda_sync_reg[1];

   // ****************************************************************
   // protocol engine
   // ****************************************************************
   target_state_type state_reg, state_next, after_reg, after_next;
   logic [7:0]       shift_reg, shift_next, ptr_reg, ptr_next;
   logic [2:0]       bit_reg, bit_next;
   logic             oe_reg, oe_next, ack_en_reg, ack_en_next;
   logic             half_reg, half_next, host_ack_reg, host_ack_next;
   reg_write_type    wr_reg, wr_next;
   logic [7:0]       new_byte;

   always_comb begin
      state_next    = state_reg;
      after_next    = after_reg;
      shift_next    = shift_reg;
      ptr_next      = ptr_reg;
      bit_next      = bit_reg;
      oe_next       = oe_reg;
      ack_en_next   = ack_en_reg;
      half_next     = half_reg;
      host_ack_next = host_ack_reg;
      wr_next       = '0;
      new_byte      = {shift_reg[6:0], sda_now};
      if (start_seen) begin
         state_next = ST_ADDR;
         bit_next   = 3'h0;
         oe_next    = 1'b0;
      end else if (stop_seen) begin
         state_next = ST_IDLE;
         oe_next    = 1'b0;
      end else begin
         unique case (state_reg)
            ST_IDLE: begin
               oe_next = 1'b0;
            end
            ST_ADDR, ST_PTR, ST_WDATA: begin
               if (scl_rise) begin
                  shift_next = new_byte;
                  bit_next   = bit_reg + 3'h1;
                  if (bit_reg == 3'h7) begin
                     half_next   = 1'b0;
                     state_next  = ST_ACK;
                     ack_en_next = 1'b1;
                     after_next  = ST_WDATA;
                     if (state_reg == ST_ADDR) begin
                        ack_en_next = (new_byte[7:1] == TARGET_ADDRESS);
                        after_next  = (new_byte[7:1] != TARGET_ADDRESS) ? ST_IDLE :
                                      (new_byte[0] ? ST_RDATA : ST_PTR);
                     end else if (state_reg == ST_PTR) begin
                        ptr_next = new_byte;
                     end else begin
                        wr_next  = '{strobe: 1'b1, addr: ptr_reg, data: new_byte};
                        ptr_next = ptr_reg + 8'h01;
                     end
                  end
               end
            end
            ST_ACK: begin
               if (scl_fall) begin
                  half_next = ~half_reg;
                  if (!half_reg) begin
                     oe_next = ack_en_reg;
                  end else begin
                     state_next = after_reg;
                     bit_next   = 3'h0;
                     oe_next    = 1'b0;
                     if (after_reg == ST_RDATA) begin
                        shift_next = read_data_i;
                        oe_next    = ~read_data_i[7];
                     end
                  end
               end
            end
            ST_RDATA: begin
               if (scl_rise) begin
                  bit_next      = bit_reg + 3'h1;
                  host_ack_next = 1'b0;
               end
               if (scl_fall) begin
                  if (bit_reg == 3'h0 && !host_ack_reg) begin
                     // byte sent: let go of the line for the host's answer
                     oe_next       = 1'b0;
                     ptr_next      = ptr_reg + 8'h01;
                     host_ack_next = 1'b1;
                  end else if (host_ack_reg) begin
                     shift_next    = read_data_i;
                     oe_next       = ~read_data_i[7];
                     host_ack_next = 1'b0;
                  end else begin
                     shift_next = {shift_reg[6:0], 1'b0};
                     oe_next    = ~shift_reg[6];
                  end
               end
               if (scl_rise && host_ack_reg) begin
                  // a not-acknowledge ends the read burst
                  bit_next      = 3'h0;
                  host_ack_next = ~sda_now;
                  if (sda_now) begin
                     state_next = ST_IDLE;
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         state_reg    <= ST_IDLE;
         after_reg    <= ST_IDLE;
         shift_reg    <= 8'h00;
         ptr_reg      <= 8'h00;
         bit_reg      <= 3'h0;
         oe_reg       <= 1'b0;
         ack_en_reg   <= 1'b0;
         half_reg     <= 1'b0;
         host_ack_reg <= 1'b0;
         wr_reg       <= '0;
      end else begin
         state_reg    <= state_next;
         after_reg    <= after_next;
         shift_reg    <= shift_next;
         ptr_reg      <= ptr_next;
         bit_reg      <= bit_next;
         oe_reg       <= oe_next;
         ack_en_reg   <= ack_en_next;
         half_reg     <= half_next;
         host_ack_reg <= host_ack_next;
         wr_reg       <= wr_next;
      end
   end

   assign sda_oe_o  = oe_reg;
   assign pointer_o = ptr_reg;
   assign write_o   = wr_reg;

endmodule
`default_nettype wire

// ===== sim/input_limit_regs_tb.sv
// self-checking bench for the input limit and conversion register slice
`timescale 1ns/10ps
`default_nettype none
module input_limit_regs_tb;
   import charger_regs_pkg::*;
   // ****************************************************************
   // clock, pins and design
   // ****************************************************************
   logic               sys_clk_i = 1'b0;
   logic               rst_i = 1'b1;
   logic               input_attached_i = 1'b0;
   charger_status_type status_i = '0;
   logic               scl, host_low, sda_line, dev_sda, dev_oe, use_abs;
   logic [13:0]        abs_mv;
   logic [7:0]         rd [4];
   int                 err_total = 0;
   int                 n_compared = 0;
   int                 cycles = 0;

   always #4 sys_clk_i = ~sys_clk_i;
   // pull-up: line is high unless someone pulls it low
   assign sda_line = ~(host_low | (dev_oe & ~dev_sda));

   input_limit_regs dut_u (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .scl_i(scl),
      .sda_i(sda_line), .sda_o(dev_sda), .sda_oe_o(dev_oe),
      .input_attached_i(input_attached_i), .status_i(status_i),
      .use_absolute_limit_o(use_abs), .absolute_limit_mv_o(abs_mv));
   serial_host_model host_u (.sys_clk_i(sys_clk_i), .sda_line_i(sda_line),
      .scl_o(scl), .sda_low_o(host_low));

   // ****************************************************************
   // shared tasks
   // ****************************************************************
   task automatic complete_run();
      $display("compared %0d, mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // ceiling well above the roughly 12k cycles the scenarios need
   always @(posedge sys_clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         err_total++;
         complete_run();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   function automatic logic [31:0] mv(input logic [6:0] c);
      return 32'd2600 + 32'(c) * 32'd100;
   endfunction

   task automatic send(input logic [7:0] d, input logic exp_ack);
      logic ack;
      host_u.write_byte(d, ack);
      check(32'(ack), 32'(exp_ack));
   endtask

   task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
      host_u.start_cond();
      send({TARGET_ADDRESS_DEFAULT, 1'b0}, 1'b1);
      send(a, 1'b1);
      send(d, 1'b1);
      host_u.stop_cond();
   endtask

   task automatic reg_read(input logic [7:0] a, input int n);
      host_u.start_cond();
      send({TARGET_ADDRESS_DEFAULT, 1'b0}, 1'b1);
      send(a, 1'b1);
      host_u.start_cond();
      send({TARGET_ADDRESS_DEFAULT, 1'b1}, 1'b1);
      for (int i = 0; i < n; i++) begin
         host_u.read_byte(i == n - 1, rd[i]);
      end
      host_u.stop_cond();
   endtask

   task automatic check_limit(input logic m, input logic [6:0] c);
      host_u.tick(4);
      check(32'(use_abs), 32'(m));
      check(32'(abs_mv), mv(c));
      reg_read(INPUT_LIMIT_CFG_OFFSET, 1);
      check(32'(rd[0]), {24'h0, m, c});
   endtask

   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic power_on_defaults();
      check_limit(1'b0, 7'h12);
   endtask

   // boundary codes, both method settings
   task automatic absolute_limit_codes();
      logic [7:0] tbl [4] = '{8'h95, 8'hff, 8'h80, 8'h7f};
      foreach (tbl[i]) begin
         reg_write(INPUT_LIMIT_CFG_OFFSET, tbl[i]);
         check_limit(tbl[i][7], tbl[i][6:0]);
      end
   endtask

   // attach reloads; a level that stays high must not reload again
   task automatic attach_reload();
      reg_write(INPUT_LIMIT_CFG_OFFSET, 8'hc1);
      @(posedge sys_clk_i);
      input_attached_i <= 1'b1;
      check_limit(1'b0, 7'h12);
      reg_write(INPUT_LIMIT_CFG_OFFSET, 8'hc1);
      check_limit(1'b1, 7'h41);
      @(posedge sys_clk_i);
      input_attached_i <= 1'b0;
   endtask

   // burst across both readings and the reserved slot, then ignored writes
   task automatic status_readback();
      @(posedge sys_clk_i);
      status_i <= '{thermal_regulation: 1'b1, battery_code: 7'h55, system_code: 7'h2a};
      reg_read(THERMAL_BATTERY_OFFSET, 4);
      check(32'(rd[0]), 32'hd5);
      check(32'(rd[1]), 32'h2a);
      check(32'(rd[2]), 32'(RESERVED_READ_VALUE));
      check(32'(rd[3]), 32'(UNMAPPED_READ_VALUE));
      @(posedge sys_clk_i);
      status_i <= '{thermal_regulation: 1'b0, battery_code: 7'h7f, system_code: 7'h7f};
      reg_write(THERMAL_BATTERY_OFFSET, 8'h00);
      reg_write(SYSTEM_VOLTAGE_OFFSET, 8'h00);
      reg_read(THERMAL_BATTERY_OFFSET, 2);
      check(32'(rd[0]), 32'h7f);
      check(32'(rd[1]), 32'h7f);
   endtask

   task automatic wrong_address();
      host_u.start_cond();
      send({~TARGET_ADDRESS_DEFAULT, 1'b0}, 1'b0);
      host_u.stop_cond();
      check_limit(1'b1, 7'h41);
   endtask

   // mid-run reset drops a programmed absolute setting back to defaults
   task automatic midrun_reset();
      @(posedge sys_clk_i);
      rst_i <= 1'b1;
      host_u.tick(2);
      check(32'(use_abs), 32'h0);
      check(32'(abs_mv), 32'd2600);
      rst_i <= 1'b0;
      host_u.tick(4);
      check_limit(1'b0, 7'h12);
   endtask

   initial begin
      host_u.tick(2);
      rst_i <= 1'b0;
      host_u.tick(4);
      power_on_defaults();
      absolute_limit_codes();
      attach_reload();
      status_readback();
      wrong_address();
      midrun_reset();
      complete_run();
   end
endmodule
`default_nettype wire

// ===== sim/serial_host_model.sv
// two-wire bus host model that drives the serial pins of the register slice
`timescale 1ns/10ps
`default_nettype none
module serial_host_model (
   // clock
   input  wire logic sys_clk_i,
   // bus pins
   input  wire logic sda_line_i,
   output logic      scl_o,
   output logic      sda_low_o
);
   // ****************************************************************
   // bit timing
   // ****************************************************************
   // quarter phase of 4 clocks keeps well clear of the target's synchronisers
   localparam int QTR = 4;

   initial begin
      scl_o = 1'b1;
      sda_low_o = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk_i);
   endtask

   task automatic bit_out(input logic b);
      @(posedge sys_clk_i);
      sda_low_o <= ~b;
      tick(QTR);
      scl_o <= 1'b1;
      tick(2 * QTR);
      scl_o <= 1'b0;
      tick(QTR);
   endtask

   // sampled mid high phase, long after the target's data change
   task automatic bit_in(output logic b);
      @(posedge sys_clk_i);
      sda_low_o <= 1'b0;
      tick(QTR);
      scl_o <= 1'b1;
      tick(QTR);
      b = sda_line_i;
      tick(QTR);
      scl_o <= 1'b0;
      tick(QTR);
   endtask

   // ****************************************************************
   // framing
   // ****************************************************************
   // also serves as repeated start, since it begins with the data line released
   task automatic start_cond();
      @(posedge sys_clk_i);
      sda_low_o <= 1'b0;
      tick(QTR);
      scl_o <= 1'b1;
      tick(2 * QTR);
      sda_low_o <= 1'b1;
      tick(2 * QTR);
      scl_o <= 1'b0;
      tick(QTR);
   endtask

   task automatic stop_cond();
      @(posedge sys_clk_i);
      sda_low_o <= 1'b1;
      tick(QTR);
      scl_o <= 1'b1;
      tick(2 * QTR);
      sda_low_o <= 1'b0;
      tick(2 * QTR);
   endtask

   task automatic write_byte(input logic [7:0] d, output logic ack);
      logic a;
      for (int i = 7; i >= 0; i--) begin
         bit_out(d[i]);
      end
      bit_in(a);
      ack = ~a;
   endtask

   task automatic read_byte(input logic last, output logic [7:0] d);
      logic b;
      for (int i = 7; i >= 0; i--) begin
         bit_in(b);
         d[i] = b;
      end
      bit_out(last);
   endtask
endmodule
`default_nettype wire
